// [logic/gp_top.sv]
// GPIO data registers, pin sharing and AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gp_defines.svh"
module gp_top #(
  parameter int ADDR_W = 18
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe,
  input wire gp_pkg::gp_alt_out_type alt_out,
  output gp_pkg::gp_alt_in_type alt_in
);

  // =====================================================
  // Elaboration check
  // Index 0xc040 times four needs 18 address bits
  if (ADDR_W < 18)
  begin : g_chk
    $error("gp_top needs at least 18 address bits");
  end

  // =====================================================
  // Helper functions
  // Byte address to register index; bit 16 flags that the upper bits are clear
  function automatic logic [16:0] to_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] up;
    up = a >> 18;
    to_idx = {(up == '0), a[17:2]};
  endfunction

  // Merge a write into a 16-bit register by byte lane
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    merge16 = old;
    if (strb[0])
      merge16[7:0] = data[7:0];
    if (strb[1])
      merge16[15:8] = data[15:8];
  endfunction

  function automatic logic is_reg(input logic [15:0] idx);
    is_reg = (idx == `GP_IDX_OUT_LO) || (idx == `GP_IDX_IN_LO)
      || (idx == `GP_IDX_DIR_LO) || (idx == `GP_IDX_OUT_HI)
      || (idx == `GP_IDX_IN_HI) || (idx == `GP_IDX_DIR_HI)
      || (idx == `GP_IDX_FSEL);
  endfunction

  // =====================================================
  // State and helpers
  gp_pkg::gp_top_state_type q, s;
  logic [31:0] sy;
  logic [31:0] alt_sel;
  logic [31:0] alt_o;
  logic [31:0] alt_oe;
  logic [31:0] gp_o;
  logic [31:0] gp_oe;
  logic [16:0] aw_dec;
  logic [16:0] ar_dec;
  logic [15:0] fsel_w;
  logic commit;
  logic [8:0] fs;

  gp_sync #(
    .W(32)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_i),
    .q(sy)
  );

  gp_pinmux u_mux (
    .fsel(s.fsel),
    .alt(alt_out),
    .sel(alt_sel),
    .o(alt_o),
    .oe(alt_oe)
  );

  // =====================================================
  // Next state
  always_comb
  begin
    s = q;
    aw_dec = to_idx(s_axi_awaddr);
    ar_dec = to_idx(s_axi_araddr);
    fsel_w = 16'h0000;
    commit = q.aw_ok && q.w_ok && !q.bvalid;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && q.awready)
    begin
      s.aw_ok = 1'b1;
      s.aw_hit = aw_dec[16] && is_reg(aw_dec[15:0]);
      s.aw_idx = aw_dec[15:0];
    end
    if (s_axi_wvalid && q.wready)
    begin
      s.w_ok = 1'b1;
      s.wdata = s_axi_wdata[15:0];
      s.wstrb = s_axi_wstrb[1:0];
    end

    // Commit one cycle after both halves are held
    if (commit)
    begin
      s.aw_ok = 1'b0;
      s.w_ok = 1'b0;
      s.bvalid = 1'b1;
      s.bresp = q.aw_hit ? `GP_RESP_OKAY : `GP_RESP_DECERR;
      if (q.aw_hit)
      begin
        if (q.aw_idx == `GP_IDX_OUT_LO)
          s.out_lo = merge16(q.out_lo, q.wdata, q.wstrb);
        if (q.aw_idx == `GP_IDX_OUT_HI)
          s.out_hi = merge16(q.out_hi, q.wdata, q.wstrb);
        if (q.aw_idx == `GP_IDX_DIR_LO)
          s.dir_lo = merge16(q.dir_lo, q.wdata, q.wstrb);
        if (q.aw_idx == `GP_IDX_DIR_HI)
          s.dir_hi = merge16(q.dir_hi, q.wdata, q.wstrb);
        if (q.aw_idx == `GP_IDX_FSEL)
        begin
          fsel_w = merge16({7'h00, q.fsel}, q.wdata, q.wstrb);
          s.fsel = fsel_w[8:0];
        end
        // Input registers accept the write and keep showing pin levels
      end
    end
    else if (q.bvalid && s_axi_bready)
      s.bvalid = 1'b0;

    // Read: data are captured at the address edge, so rvalid follows at once
    if (s_axi_arvalid && q.arready)
    begin
      s.rvalid = 1'b1;
      s.rresp = `GP_RESP_OKAY;
      s.rdata = 16'h0000;
      if (!ar_dec[16] || !is_reg(ar_dec[15:0]))
        s.rresp = `GP_RESP_DECERR;
      else if (ar_dec[15:0] == `GP_IDX_OUT_LO)
        s.rdata = q.out_lo;
      else if (ar_dec[15:0] == `GP_IDX_OUT_HI)
        s.rdata = q.out_hi;
      else if (ar_dec[15:0] == `GP_IDX_IN_LO)
        s.rdata = sy[15:0];
      else if (ar_dec[15:0] == `GP_IDX_IN_HI)
        s.rdata = sy[31:16];
      else if (ar_dec[15:0] == `GP_IDX_DIR_LO)
        s.rdata = q.dir_lo;
      else if (ar_dec[15:0] == `GP_IDX_DIR_HI)
        s.rdata = q.dir_hi;
      else
        s.rdata = {7'h00, q.fsel};
    end
    else if (q.rvalid && s_axi_rready)
      s.rvalid = 1'b0;

    // One write and one read in flight at most
    s.awready = !s.aw_ok && !s.bvalid;
    s.wready = !s.w_ok && !s.bvalid;
    s.arready = !s.rvalid;

    // Pin drive: general purpose values unless a function owns the pin
    gp_o = {s.out_hi, s.out_lo};
    gp_oe = {s.dir_hi, s.dir_lo};
    s.pin_o = (alt_sel & alt_o) | (~alt_sel & gp_o);
    s.pin_oe = (alt_sel & alt_oe) | (~alt_sel & gp_oe);

    // Levels handed to the function units; idle levels when not selected
    fs = s.fsel;
    s.alt_in.eeprom_serial_data_i = fs[`GP_FS_EEPROM]
      ? sy[`GP_PIN_EE_DAT] : 1'b1;
    s.alt_in.uart_rx = fs[`GP_FS_UART] ? sy[`GP_PIN_UART_RX] : 1'b1;
    s.alt_in.ext_interrupt_one = fs[`GP_FS_EXT_INTERRUPT_ONE] & sy[`GP_PIN_EXT_INTERRUPT_ONE];
    s.alt_in.ext_interrupt_zero = fs[`GP_FS_EXT_INTERRUPT_ZERO] & sy[`GP_PIN_EXT_INTERRUPT_ZERO];
    s.alt_in.mailbox_select = fs[`GP_FS_HSHAKE] & sy[`GP_PIN_MBX];
    s.alt_in.port_select_n = !fs[`GP_FS_HSHAKE] | sy[`GP_PIN_PSEL];
    s.alt_in.port_write_strobe_n = !fs[`GP_FS_HSHAKE] | sy[`GP_PIN_WSTB];
    s.alt_in.port_read_strobe_n = !fs[`GP_FS_HSHAKE] | sy[`GP_PIN_RSTB];
    s.alt_in.shared_port_bits_i = fs[`GP_FS_PORT] ? sy[15:0] : 16'h0000;
  end

  // =====================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.out_lo <= `GP_RST_OUT;
      q.out_hi <= `GP_RST_OUT;
      q.dir_lo <= `GP_RST_DIR;
      q.dir_hi <= `GP_RST_DIR;
      q.fsel <= `GP_RST_FSEL;
      q.alt_in.eeprom_serial_data_i <= 1'b1;
      q.alt_in.uart_rx <= 1'b1;
      q.alt_in.port_select_n <= 1'b1;
      q.alt_in.port_write_strobe_n <= 1'b1;
      q.alt_in.port_read_strobe_n <= 1'b1;
    end
    else
      q <= s;
  end

  // =====================================================
  // Outputs
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {16'h0000, q.rdata};
  assign pin_o = q.pin_o;
  assign pin_oe = q.pin_oe;
  assign alt_in = q.alt_in;

endmodule

// [logic/gp_defines.svh]
// Register map, field positions and reset values of the GPIO pin block
// Behaviour
// - Upper output register drives pins 31..16 output values.
// - Lower output register holds output values of pins 15..0.
// - Lower input register returns current levels of pins 15..0.
// - Upper input register returns current levels of pins 31..16.
// - Pin 31 may carry EEPROM clock, pin 30 EEPROM data.
// - Pin 29 may drive the USB data-line pull-up control.
// - Pin 28 may carry UART transmit, pin 27 UART receive.
// - Pin 26 may drive the peripheral power cut output.
// - Pin 25 may act as external interrupt input one.
// - Pins 24..21 may carry pulse outputs; pin 24 may be interrupt zero.
// - Pin 20 may output the transfer request handshake.
// - Pin 19 input selects mailbox buffers when high, status when low.
// - Pins 15..0 may form data port bits 15..0 in same order.
// - Direction bit one makes pin an output, zero an input.
// - Output registers read back stored values even when not driven.
// - An enabled special function overrides general purpose behaviour.
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// =====================================================
// Register indices (byte address is four times the index)
`define GP_IDX_OUT_LO 16'hc01e
`define GP_IDX_IN_LO 16'hc020
`define GP_IDX_DIR_LO 16'hc022
`define GP_IDX_OUT_HI 16'hc024
`define GP_IDX_IN_HI 16'hc026
`define GP_IDX_DIR_HI 16'hc028
`define GP_IDX_FSEL 16'hc040

// =====================================================
// Reset values
`define GP_RST_OUT 16'h0000
`define GP_RST_DIR 16'h0000
`define GP_RST_FSEL 9'h000

// =====================================================
// Function select bits
`define GP_FS_EEPROM 0
`define GP_FS_PULLUP 1
`define GP_FS_UART 2
`define GP_FS_POWER 3
`define GP_FS_EXT_INTERRUPT_ONE 4
`define GP_FS_PULSE 5
`define GP_FS_EXT_INTERRUPT_ZERO 6
`define GP_FS_HSHAKE 7
`define GP_FS_PORT 8

// =====================================================
// Pin positions of shared functions
`define GP_PIN_EE_CLK 31
`define GP_PIN_EE_DAT 30
`define GP_PIN_PULLUP 29
`define GP_PIN_UART_TX 28
`define GP_PIN_UART_RX 27
`define GP_PIN_POWER 26
`define GP_PIN_EXT_INTERRUPT_ONE 25
`define GP_PIN_PULSE_HI 24
`define GP_PIN_PULSE_LO 21
`define GP_PIN_EXT_INTERRUPT_ZERO 24
`define GP_PIN_XFER 20
`define GP_PIN_MBX 19
`define GP_PIN_PSEL 18
`define GP_PIN_WSTB 17
`define GP_PIN_RSTB 16

// =====================================================
// Bus responses
`define GP_RESP_OKAY 2'b00
`define GP_RESP_DECERR 2'b11

`endif

// [logic/gp_pkg.sv]
// Types shared by the GPIO pin block
package gp_pkg;

  // ===================================================
  // Signals from the core's special function units toward the pins
  typedef struct packed {
    logic eeprom_serial_clock;
    logic eeprom_serial_data_o;
    logic eeprom_serial_data_oe;
    logic bus_pullup_control;
    logic uart_tx;
    logic peripheral_power_cut;
    logic [3:0] pulse_out;
    logic transfer_request;
    logic [15:0] shared_port_bits_o;
    logic shared_port_bits_oe;
  } gp_alt_out_type;

  // ===================================================
  // Signals from the pins toward the core's special function units
  typedef struct packed {
    logic eeprom_serial_data_i;
    logic uart_rx;
    logic ext_interrupt_one;
    logic ext_interrupt_zero;
    logic mailbox_select;
    logic port_select_n;
    logic port_write_strobe_n;
    logic port_read_strobe_n;
    logic [15:0] shared_port_bits_i;
  } gp_alt_in_type;

  // ===================================================
  // Whole state of the top module
  typedef struct packed {
    logic aw_ok;
    logic aw_hit;
    logic [15:0] aw_idx;
    logic w_ok;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [15:0] out_lo;
    logic [15:0] out_hi;
    logic [15:0] dir_lo;
    logic [15:0] dir_hi;
    logic [8:0] fsel;
    logic [31:0] pin_o;
    logic [31:0] pin_oe;
    gp_alt_in_type alt_in;
  } gp_top_state_type;

endpackage

// [logic/gp_sync.sv]
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module gp_sync #(
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gp_sync_state_type;

  gp_sync_state_type r, r_nxt;

  if (W < 1)
  begin : g_chk
    $error("gp_sync width must be at least one");
  end

  // First stage feeds only the second
  always_comb
  begin
    r_nxt.s1 = d;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= r_nxt;
  end

  assign q = r.s2;
endmodule

// [logic/gp_pinmux.sv]
// Special function override map for the 32 shared pins
`timescale 1ns/1ps
`include "gp_defines.svh"
module gp_pinmux (
  input wire logic [8:0] fsel,
  input wire gp_pkg::gp_alt_out_type alt,
  output logic [31:0] sel,
  output logic [31:0] o,
  output logic [31:0] oe
);
  always_comb
  begin
    sel = '0;
    o = '0;
    oe = '0;
    if (fsel[`GP_FS_EEPROM])
    begin
      sel[`GP_PIN_EE_CLK] = 1'b1;
      o[`GP_PIN_EE_CLK] = alt.eeprom_serial_clock;
      oe[`GP_PIN_EE_CLK] = 1'b1;
      sel[`GP_PIN_EE_DAT] = 1'b1;
      o[`GP_PIN_EE_DAT] = alt.eeprom_serial_data_o;
      oe[`GP_PIN_EE_DAT] = alt.eeprom_serial_data_oe;
    end
    if (fsel[`GP_FS_PULLUP])
    begin
      sel[`GP_PIN_PULLUP] = 1'b1;
      o[`GP_PIN_PULLUP] = alt.bus_pullup_control;
      oe[`GP_PIN_PULLUP] = 1'b1;
    end
    if (fsel[`GP_FS_UART])
    begin
      sel[`GP_PIN_UART_TX] = 1'b1;
      o[`GP_PIN_UART_TX] = alt.uart_tx;
      oe[`GP_PIN_UART_TX] = 1'b1;
      sel[`GP_PIN_UART_RX] = 1'b1;
    end
    if (fsel[`GP_FS_POWER])
    begin
      sel[`GP_PIN_POWER] = 1'b1;
      o[`GP_PIN_POWER] = alt.peripheral_power_cut;
      oe[`GP_PIN_POWER] = 1'b1;
    end
    if (fsel[`GP_FS_EXT_INTERRUPT_ONE])
      sel[`GP_PIN_EXT_INTERRUPT_ONE] = 1'b1;
    if (fsel[`GP_FS_PULSE])
    begin
      sel[`GP_PIN_PULSE_HI:`GP_PIN_PULSE_LO] = 4'hf;
      o[`GP_PIN_PULSE_HI:`GP_PIN_PULSE_LO] = alt.pulse_out;
      oe[`GP_PIN_PULSE_HI:`GP_PIN_PULSE_LO] = 4'hf;
    end
    // Interrupt zero takes pin 24 from pulse output 3 when both are on
    if (fsel[`GP_FS_EXT_INTERRUPT_ZERO])
    begin
      sel[`GP_PIN_EXT_INTERRUPT_ZERO] = 1'b1;
      o[`GP_PIN_EXT_INTERRUPT_ZERO] = 1'b0;
      oe[`GP_PIN_EXT_INTERRUPT_ZERO] = 1'b0;
    end
    if (fsel[`GP_FS_HSHAKE])
    begin
      sel[`GP_PIN_XFER:`GP_PIN_RSTB] = 5'h1f;
      o[`GP_PIN_XFER] = alt.transfer_request;
      oe[`GP_PIN_XFER] = 1'b1;
    end
    if (fsel[`GP_FS_PORT])
    begin
      sel[15:0] = 16'hffff;
      o[15:0] = alt.shared_port_bits_o;
      oe[15:0] = {16{alt.shared_port_bits_oe}};
    end
  end
endmodule

// [tb/gp_board.sv]
// Far-side board model for the 32 shared pins
`timescale 1ns/1ps
module gp_board (
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_i
);
  // ====================
  // Wire level
  // The block wins where it drives; elsewhere the board drives strobes,
  // mailbox select, port bits and the other inputs
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule

// [tb/gp_monitor.sv]
// Concurrent checks on the GPIO block ports
`timescale 1ns/1ps
`include "gp_defines.svh"
module gp_monitor #(
  parameter int ADDR_W = 18
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe
);
  logic [31:0] pin_d;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
  begin
    pin_d <= pin_i;
  end
  // ====================
  // Assertions
  a_reset_clears: assert property (disable iff (1'b0)
    !aresetn |=> pin_oe == 32'h0 && pin_o == 32'h0) else $error("pins not cleared by reset");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken busy");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0 |=>
    s_axi_rresp == `GP_RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
  a_input_sync: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {`GP_IDX_IN_LO, 2'h0} &&
    pin_i == $past(pin_i, 1) && pin_i == $past(pin_i, 2) && pin_i == $past(pin_i, 3) &&
    $past(aresetn, 1) && $past(aresetn, 2) && $past(aresetn, 3)
    |=> s_axi_rdata[15:0] == pin_d[15:0]) else $error("input level not read");
endmodule
bind gp_top gp_monitor #(.ADDR_W(ADDR_W)) u_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pin_i, .pin_o, .pin_oe);

// [tb/testbench.sv]
// Self-checking bench for the GPIO data and pin sharing block
`timescale 1ns/1ps
`include "gp_defines.svh"
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pin_i, pin_o, pin_oe, ext_val, lvl, fo, foe;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ol, oh, dl, dh;
  gp_pkg::gp_alt_out_type alt_out;
  gp_pkg::gp_alt_in_type alt_in, ei;
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  logic [15:0] rx [5] = '{`GP_IDX_OUT_LO, `GP_IDX_OUT_HI, `GP_IDX_DIR_LO, `GP_IDX_DIR_HI,
    `GP_IDX_FSEL};
  logic [31:0] fm [10] = '{32'hc0000000, 32'h20000000, 32'h18000000, 32'h04000000,
    32'h02000000, 32'h01e00000, 32'h01000000, 32'h001f0000, 32'h0000ffff, 32'h01e00000};
  int n_mismatch, checks, cyc;
  gp_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i,
    .pin_o, .pin_oe, .alt_out, .alt_in);
  gp_board u_board (.pin_o, .pin_oe, .ext_val, .pin_i);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ====================
  // Compare and verdict
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (s_axi_bvalid && s_axi_bready)
      check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (cyc > 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ====================
  // Bus master; responses are stalled a random few cycles
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] st,
    input logic [1:0] rs);
    logic a, w;
    exp_b.push_back(rs);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= {2'h0, st};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    while (!(a && w))
    begin
      @(posedge aclk);
      if (s_axi_awready && !a)
      begin
        s_axi_awvalid <= 1'b0;
        a = 1'b1;
      end
      if (s_axi_wready && !w)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] rs);
    exp_r.push_back({rs, 16'h0, d});
    repeat (3) @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // ====================
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    ext_val = 32'h0;
    alt_out = '0;
    void'($urandom(15));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rx[i]) rd(rx[i], 16'h0, `GP_RESP_OKAY);
    check(34'(pin_oe), 34'h0);
    $display("test reset values done");
    ol = 16'($urandom);
    oh = 16'($urandom);
    ext_val <= $urandom;
    wr(`GP_IDX_OUT_LO, ol, 2'h3, `GP_RESP_OKAY);
    wr(`GP_IDX_OUT_HI, oh, 2'h3, `GP_RESP_OKAY);
    wr(`GP_IDX_OUT_LO, 16'hc3a5, 2'h1, `GP_RESP_OKAY);
    ol[7:0] = 8'ha5;
    wr(`GP_IDX_OUT_HI, 16'h5a3c, 2'h2, `GP_RESP_OKAY);
    oh[15:8] = 8'h5a;
    check(34'(pin_oe), 34'h0);
    rd(`GP_IDX_OUT_LO, ol, `GP_RESP_OKAY);
    rd(`GP_IDX_OUT_HI, oh, `GP_RESP_OKAY);
    rd(`GP_IDX_IN_LO, ext_val[15:0], `GP_RESP_OKAY);
    dl = 16'($urandom);
    dh = 16'($urandom);
    wr(`GP_IDX_DIR_LO, dl, 2'h3, `GP_RESP_OKAY);
    wr(`GP_IDX_DIR_HI, dh, 2'h3, `GP_RESP_OKAY);
    check(34'(pin_oe), 34'({dh, dl}));
    check(34'(pin_o & pin_oe), 34'({oh, ol} & {dh, dl}));
    lvl = ({dh, dl} & {oh, ol}) | (~{dh, dl} & ext_val);
    rd(`GP_IDX_IN_LO, lvl[15:0], `GP_RESP_OKAY);
    rd(`GP_IDX_IN_HI, lvl[31:16], `GP_RESP_OKAY);
    wr(`GP_IDX_IN_LO, 16'hffff, 2'h3, `GP_RESP_OKAY);
    rd(`GP_IDX_IN_LO, lvl[15:0], `GP_RESP_OKAY);
    wr(16'h0, 16'h1234, 2'h3, `GP_RESP_DECERR);
    rd(16'h0, 16'h0, `GP_RESP_DECERR);
    $display("test data registers done");
    // Last pass turns pulses and interrupt zero on together: pin 24 must be an input
    for (int b = 0; b < 10; b++)
    begin
      alt_out <= gp_pkg::gp_alt_out_type'(28'($urandom));
      ext_val <= $urandom;
      wr(`GP_IDX_FSEL, (b < 9) ? 16'(16'h1 << b) : 16'h0060, 2'h3, `GP_RESP_OKAY);
      repeat (4) @(posedge aclk);
      fo = 32'h0;
      foe = 32'h0;
      ei = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0};
      case (b)
        0: {foe[31:30], fo[31:30]} = {1'b1, alt_out.eeprom_serial_data_oe,
          alt_out.eeprom_serial_clock, alt_out.eeprom_serial_data_o};
        1: {foe[29], fo[29]} = {1'b1, alt_out.bus_pullup_control};
        2: {foe[28], fo[28]} = {1'b1, alt_out.uart_tx};
        3: {foe[26], fo[26]} = {1'b1, alt_out.peripheral_power_cut};
        5: {foe[24:21], fo[24:21]} = {4'hf, alt_out.pulse_out};
        7: {foe[20], fo[20]} = {1'b1, alt_out.transfer_request};
        8: {foe[15:0], fo[15:0]} = {{16{alt_out.shared_port_bits_oe}},
          alt_out.shared_port_bits_o};
        9: {foe[23:21], fo[23:21]} = {3'h7, alt_out.pulse_out[2:0]};
        default: ;
      endcase
      lvl = (foe & fo) | (~foe & ext_val);
      case (b)
        0: ei.eeprom_serial_data_i = lvl[30];
        2: ei.uart_rx = lvl[27];
        4: ei.ext_interrupt_one = lvl[25];
        6, 9: ei.ext_interrupt_zero = lvl[24];
        7: {ei.mailbox_select, ei.port_select_n, ei.port_write_strobe_n,
          ei.port_read_strobe_n} = lvl[19:16];
        8: ei.shared_port_bits_i = lvl[15:0];
        default: ;
      endcase
      check(34'(pin_oe & fm[b]), 34'(foe));
      check(34'(pin_o & foe), 34'(fo & foe));
      check(34'(alt_in), 34'(ei));
    end
    $display("test shared functions done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check(34'(pin_oe), 34'h0);
    rd(`GP_IDX_OUT_HI, 16'h0, `GP_RESP_OKAY);
    rd(`GP_IDX_FSEL, 16'h0, `GP_RESP_OKAY);
    $display("test second reset done");
    give_verdict();
  end
endmodule
